/* File: flash_id_cmd.sv */
// Identifier and wake-up instruction handler of a serial flash slave
`timescale 1ns/1ps
`default_nettype none
`include "flash_id_map.svh"

module flash_id_cmd #(
  parameter logic [7:0] MFR_ID = 8'h5A,   // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'h13,   // Arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h40, // Arbitrary value
  parameter logic [7:0] CAPACITY = 8'h14, // Arbitrary value
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF,
  parameter int WAKE_WAIT_NS = 3000,
  parameter int WAKE_IDENT_WAIT_NS = 1800
) (
  // Core clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link
  input wire logic sclk,
  input wire logic csN,
  input wire logic [3:0] ioIn,
  output logic [3:0] ioOut,
  output logic [3:0] ioOeN,
  // Device status
  input wire logic busy,
  output logic powerDown,
  output logic waking
);
  localparam int WAKE_CYC = (WAKE_WAIT_NS + `CLK_PERIOD_NS - 1)
                            / `CLK_PERIOD_NS;
  localparam int IDENT_CYC = (WAKE_IDENT_WAIT_NS + `CLK_PERIOD_NS - 1)
                             / `CLK_PERIOD_NS;

  if (WAKE_CYC < 1 || IDENT_CYC < 1 ||
      WAKE_CYC > 65535 || IDENT_CYC > 65535) begin : g_bad_time
    $error("flash_id_cmd: wake waits must be 1..65535 cycles");
  end

  // ========================================================
  // Decode helpers
  function automatic logic [6:0] startOf(input logic [7:0] op);
    unique case (op)
      `OP_RELEASE: startOf = `START_RELEASE;
      `OP_MFR_DEV: startOf = `START_MFR_DEV;
      `OP_MFR_DEV_DUAL: startOf = `START_DUAL;
      `OP_MFR_DEV_QUAD: startOf = `START_QUAD;
      `OP_UNIQUE: startOf = `START_UNIQUE;
      `OP_STD_ID: startOf = `START_STD_ID;
      default: startOf = `CNT_MAX;
    endcase
  endfunction

  function automatic logic [5:0] lastOf(input logic [7:0] op);
    unique case (op)
      `OP_RELEASE: lastOf = `LAST_RELEASE;
      `OP_MFR_DEV: lastOf = `LAST_MFR_DEV;
      `OP_MFR_DEV_DUAL: lastOf = `LAST_DUAL;
      `OP_MFR_DEV_QUAD: lastOf = `LAST_QUAD;
      `OP_UNIQUE: lastOf = `LAST_UNIQUE;
      default: lastOf = `LAST_STD_ID;
    endcase
  endfunction

  function automatic logic [3:0] oeOf(input logic [7:0] op);
    unique case (op)
      `OP_MFR_DEV_DUAL: oeOf = `OE_DUAL_N;
      `OP_MFR_DEV_QUAD: oeOf = `OE_QUAD_N;
      default: oeOf = `OE_SINGLE_N;
    endcase
  endfunction

  function automatic logic known(input logic [7:0] op);
    known = (op == `OP_RELEASE) || (op == `OP_MFR_DEV) ||
            (op == `OP_MFR_DEV_DUAL) || (op == `OP_MFR_DEV_QUAD) ||
            (op == `OP_UNIQUE) || (op == `OP_STD_ID);
  endfunction

  // Lane values for one output step, most significant first
  function automatic logic [3:0] laneBits(input logic [7:0] op,
                                          input logic [5:0] idx);
    logic [15:0] pair;
    logic [23:0] std;
    logic [63:0] uniq;
    logic [7:0] dev;
    pair = {MFR_ID, DEV_ID} << idx;
    std = {MFR_ID, MEM_TYPE, CAPACITY} << idx;
    uniq = UNIQUE_ID << idx;
    dev = DEV_ID << idx[2:0];
    unique case (op)
      `OP_RELEASE: laneBits = {2'b00, dev[7], 1'b0};
      `OP_MFR_DEV: laneBits = {2'b00, pair[15], 1'b0};
      `OP_MFR_DEV_DUAL: begin
        pair = {MFR_ID, DEV_ID} << {idx[4:0], 1'b0};
        laneBits = {2'b00, pair[15:14]};
      end
      `OP_MFR_DEV_QUAD: begin
        pair = {MFR_ID, DEV_ID} << {idx[3:0], 2'b00};
        laneBits = pair[15:12];
      end
      `OP_UNIQUE: laneBits = {2'b00, uniq[63], 1'b0};
      default: laneBits = {2'b00, std[23], 1'b0};
    endcase
  endfunction

  // ========================================================
  // Link domain: command capture on rising edges
  logic [6:0] bitCnt_q;
  logic [6:0] shift_q;
  logic [7:0] opcode_q;
  logic [1:0] tag_q;
  logic seq_q;
  logic [1:0] linkStat;
  logic blockS;
  logic sleepS;

  // Select high clears the frame state; sclk may stop between frames
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      bitCnt_q <= 7'h00;
      shift_q <= 7'h00;
    end else begin
      if (bitCnt_q != `CNT_MAX) begin
        bitCnt_q <= bitCnt_q + 7'h01;
      end
      shift_q <= {shift_q[5:0], ioIn[0]};
    end
  end

  // Kept past the frame so the core reads it after select rises
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      opcode_q <= 8'h00;
      tag_q <= `TAG_SHORT;
      seq_q <= 1'b0;
    end else begin
      if (bitCnt_q == 7'h00) begin
        seq_q <= ~seq_q;
      end
      if (bitCnt_q == 7'h07) begin
        opcode_q <= {shift_q, ioIn[0]};
      end
      if (bitCnt_q < 7'h07) begin
        tag_q <= `TAG_SHORT;
      end else if (bitCnt_q == 7'h07) begin
        tag_q <= `TAG_BARE;
      end else begin
        tag_q <= `TAG_LONG;
      end
    end
  end

  // ========================================================
  // Link domain: output on falling edges
  logic [5:0] outIdx_q;
  logic driveNow;

  flash_id_sync #(.W(2)) u_link_sync (
    .clk(sclk),
    .din(linkStat),
    .dout({blockS, sleepS})
  );

  always_comb begin
    driveNow = known(opcode_q) && (bitCnt_q >= 7'h08) &&
               (bitCnt_q >= startOf(opcode_q)) && !blockS &&
               (!sleepS || opcode_q == `OP_RELEASE);
  end

  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      ioOut <= 4'h0;
      ioOeN <= `OE_OFF_N;
      outIdx_q <= 6'h00;
    end else if (driveNow) begin
      ioOut <= laneBits(opcode_q, outIdx_q);
      ioOeN <= oeOf(opcode_q);
      if (outIdx_q == lastOf(opcode_q)) begin
        outIdx_q <= 6'h00;
      end else begin
        outIdx_q <= outIdx_q + 6'h01;
      end
    end else begin
      ioOut <= 4'h0;
      ioOeN <= `OE_OFF_N;
    end
  end

  // ========================================================
  // Core domain: frame end detection
  logic csS;
  logic csPrev_q;
  logic seen_q;
  logic pendValid_q;
  logic [9:0] pend_q;
  logic pendReady;
  logic recValid;
  logic [9:0] rec;
  logic popOk;
  logic frameEnd;
  logic blockSrc_q;
  flash_id_pkg::pwr_state_type state_q;
  logic [15:0] wakeCnt_q;
  logic powerDown_q;
  logic waking_q;

  flash_id_sync #(.W(1)) u_cs_sync (
    .clk(clk),
    .din(csN),
    .dout(csS)
  );

  assign frameEnd = csS && !csPrev_q;
  assign linkStat = {blockSrc_q, powerDown_q};

  always_ff @(posedge clk) begin
    if (rst) begin
      csPrev_q <= 1'b1;
      blockSrc_q <= 1'b0;
    end else begin
      csPrev_q <= csS;
      blockSrc_q <= waking_q || busy;
    end
  end

  // Record is stable here: sclk has stopped and select is high
  always_ff @(posedge clk) begin
    if (rst) begin
      seen_q <= 1'b0;
      pendValid_q <= 1'b0;
      pend_q <= 10'h000;
    end else begin
      if (pendValid_q && pendReady) begin
        pendValid_q <= 1'b0;
      end
      if (frameEnd) begin
        seen_q <= seq_q;
        // Frames during the wake wait are dropped
        if (seq_q != seen_q && tag_q != `TAG_SHORT &&
            !waking_q && !busy) begin
          pendValid_q <= 1'b1;
          pend_q <= {opcode_q, tag_q};
        end
      end
    end
  end

  flash_id_buf #(.W(10), .DEPTH(2)) u_buf (
    .clk(clk),
    .rst(rst),
    .inValid(pendValid_q),
    .inData(pend_q),
    .inReady(pendReady),
    .outValid(recValid),
    .outData(rec),
    .outReady(state_q == flash_id_pkg::ST_RUN)
  );

  assign popOk = recValid && (state_q == flash_id_pkg::ST_RUN);

  // ========================================================
  // Core domain: power state
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= flash_id_pkg::ST_RUN;
      powerDown_q <= 1'b0;
      waking_q <= 1'b0;
      wakeCnt_q <= 16'h0000;
    end else begin
      unique case (state_q)
        flash_id_pkg::ST_RUN: begin
          if (popOk && !busy) begin
            if (rec[9:2] == `OP_SLEEP && rec[1:0] == `TAG_BARE &&
                !powerDown_q) begin
              powerDown_q <= 1'b1;
            end
            if (rec[9:2] == `OP_RELEASE && powerDown_q) begin
              state_q <= flash_id_pkg::ST_WAKE;
              waking_q <= 1'b1;
              if (rec[1:0] == `TAG_BARE) begin
                wakeCnt_q <= 16'(WAKE_CYC - 1);
              end else begin
                wakeCnt_q <= 16'(IDENT_CYC - 1);
              end
            end
          end
        end
        flash_id_pkg::ST_WAKE: begin
          if (wakeCnt_q == 16'h0000) begin
            state_q <= flash_id_pkg::ST_RUN;
            waking_q <= 1'b0;
            powerDown_q <= 1'b0;
          end else begin
            wakeCnt_q <= wakeCnt_q - 16'h0001;
          end
        end
      endcase
    end
  end

  assign powerDown = powerDown_q;
  assign waking = waking_q;

  // ========================================================
  // Checks
  logic [15:0] wakeLen_q;

  always_ff @(posedge clk) begin
    if (rst || !waking_q) begin
      wakeLen_q <= 16'h0000;
    end else begin
      wakeLen_q <= wakeLen_q + 16'h0001;
    end
  end

  a_wake_time: assert property (@(posedge clk) disable iff (rst)
    $fell(waking_q) |-> (wakeLen_q == 16'(WAKE_CYC)) ||
                        (wakeLen_q == 16'(IDENT_CYC)))
    else $error("wake wait length wrong");

  a_wake_clears: assert property (@(posedge clk) disable iff (rst)
    $fell(waking_q) |-> !powerDown_q && state_q == flash_id_pkg::ST_RUN)
    else $error("wake end did not restore operation");

  a_busy_ignore: assert property (@(posedge clk) disable iff (rst)
    (busy && !waking_q) |=> $stable(powerDown_q) && !waking_q)
    else $error("instruction acted on while busy");

  a_sleep_enter: assert property (@(posedge clk) disable iff (rst)
    (popOk && !busy && rec[9:2] == `OP_SLEEP &&
     rec[1:0] == `TAG_BARE) |=> powerDown_q)
    else $error("sleep frame did not power down");

  a_idle_hiz: assert property (@(posedge clk) disable iff (rst)
    (csS && csPrev_q) |-> ioOeN == `OE_OFF_N)
    else $error("lines driven while deselected");

  a_ident_repeat: assert property (@(negedge sclk) disable iff (csN)
    (opcode_q == `OP_RELEASE && ioOeN == `OE_SINGLE_N)[*8] ##1
    (ioOeN == `OE_SINGLE_N) |-> ioOut[1] == $past(ioOut[1], 8))
    else $error("identifier byte not repeated");

  a_pair_repeat: assert property (@(negedge sclk) disable iff (csN)
    (opcode_q == `OP_MFR_DEV_QUAD && ioOeN == `OE_QUAD_N)[*4] ##1
    (ioOeN == `OE_QUAD_N) |-> ioOut == $past(ioOut, 4))
    else $error("maker and device bytes not alternating");

  a_std_first: assert property (@(negedge sclk) disable iff (csN)
    (bitCnt_q == 7'h08 && opcode_q == `OP_STD_ID && !blockS && !sleepS)
    |=> ioOut[1] == MFR_ID[7] && ioOeN == `OE_SINGLE_N)
    else $error("standard identity read did not start");

  a_sleep_mute: assert property (@(negedge sclk) disable iff (csN)
    (sleepS && opcode_q != `OP_RELEASE) |=> ioOeN == `OE_OFF_N)
    else $error("output driven while powered down");

  a_dummy_quiet: assert property (@(negedge sclk) disable iff (csN)
    (opcode_q == `OP_RELEASE && bitCnt_q >= 7'h08 &&
     bitCnt_q < `START_RELEASE) |=> ioOeN == `OE_OFF_N)
    else $error("identifier driven during dummy bytes");

  c_wake: cover property (@(posedge clk) disable iff (rst)
    $fell(waking_q));
  c_quad: cover property (@(negedge sclk) disable iff (csN)
    ioOeN == `OE_QUAD_N);
  c_unique: cover property (@(negedge sclk) disable iff (csN)
    opcode_q == `OP_UNIQUE && outIdx_q == `LAST_UNIQUE);
endmodule // flash_id_cmd
`default_nettype wire

/* File: flash_id_map.svh */
// Opcodes, stream offsets and timing constants of the identifier block
`ifndef FLASH_ID_MAP_SVH
`define FLASH_ID_MAP_SVH

// ==========================================================
// Opcodes
`define OP_RELEASE 8'hAB
`define OP_SLEEP 8'hB9
`define OP_MFR_DEV 8'h90
`define OP_MFR_DEV_DUAL 8'h92
`define OP_MFR_DEV_QUAD 8'h94
`define OP_UNIQUE 8'h4B
`define OP_STD_ID 8'h9F

// ==========================================================
// First output clock (rising edges before the first bit)
`define START_RELEASE 7'h20
`define START_MFR_DEV 7'h20
`define START_DUAL 7'h18
`define START_QUAD 7'h14
`define START_UNIQUE 7'h28
`define START_STD_ID 7'h08
`define CNT_MAX 7'h7F

// ==========================================================
// Last output step index before the stream repeats
`define LAST_RELEASE 6'h07
`define LAST_MFR_DEV 6'h0F
`define LAST_DUAL 6'h07
`define LAST_QUAD 6'h03
`define LAST_UNIQUE 6'h3F
`define LAST_STD_ID 6'h17

// ==========================================================
// Lane enables (active low) and frame length tags
`define OE_SINGLE_N 4'hD
`define OE_DUAL_N 4'hC
`define OE_QUAD_N 4'h0
`define OE_OFF_N 4'hF
`define TAG_SHORT 2'h0
`define TAG_BARE 2'h1
`define TAG_LONG 2'h2

// ==========================================================
// Timing
`define CLK_PERIOD_NS 4

`endif

/* File: flash_id_pkg.sv */
// Types shared by the identifier block
package flash_id_pkg;
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_WAKE = 2'b10
  } pwr_state_type;
endpackage

/* File: flash_id_sync.sv */
// Two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module flash_id_sync #(
  parameter int W = 1
) (
  // Destination clock
  input wire logic clk,
  // Asynchronous level in, synchronised level out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  if (W < 1) begin : g_bad_w
    $error("flash_id_sync: W must be at least 1");
  end

  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    meta_q <= din;
    dout <= meta_q;
  end
endmodule // flash_id_sync
`default_nettype wire

/* File: flash_id_buf.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module flash_id_buf #(
  parameter int W = 10,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic inValid,
  input wire logic [W-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [W-1:0] outData,
  input wire logic outReady
);
  if (W < 1 || DEPTH != 2) begin : g_bad_cfg
    $error("flash_id_buf: W >= 1 and DEPTH == 2 required");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic wrPtr_q;
  logic rdPtr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  assign inReady = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData = mem_q[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        wrPtr_q <= ~wrPtr_q;
      end
      if (pop) begin
        rdPtr_q <= ~rdPtr_q;
      end
      if (push && !pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop && !push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end
endmodule // flash_id_buf
`default_nettype wire

/* File: flash_id_host.sv */
// Link host model that frames instructions towards the identifier block
`timescale 1ns/1ps
`default_nettype none
module flash_id_host (
  // Link towards the device
  output var logic sclk,
  output var logic csN,
  output var logic [3:0] ioIn,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOeN
);
  logic [3:0] hostDat;
  logic [3:0] hostEn;
  logic [3:0] noise;
  logic [3:0] oeAny;

  // ==========================================================
  // Line resolution
  // Released lines toggle so a stale level never passes for data
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!ioOeN[i]) ioIn[i] = ioOut[i];
      else if (hostEn[i]) ioIn[i] = hostDat[i];
      else ioIn[i] = noise[i];
    end
  end

  initial begin
    sclk = 1'b0;
    // Deferred so the device's async clear sees a rising select
    csN <= 1'b1;
    hostDat = 4'h0;
    hostEn = 4'h0;
    noise = 4'h5;
    oeAny = 4'h0;
  end

  // ==========================================================
  // Clocking, 48 ns period, only inside frames
  task automatic pulse();
    // Enables looked at where settled, before the rising edge
    #23 oeAny = oeAny | ~ioOeN;
    #1 sclk = 1'b1;
    #24 sclk = 1'b0;
    noise = ~noise;
  endtask

  // Opcode single lane, then adrClk clocks of adr at the given width
  task automatic frame(input logic [7:0] op, input logic [31:0] adr,
                       input int lanes, input int adrClk, input int dumClk,
                       input int rdLanes, input int rdClk,
                       output logic [63:0] rd, output logic [3:0] oe);
    logic [39:0] sh;
    int w;
    sh = {op, adr};
    rd = 64'h0;
    oe = 4'hF;
    oeAny = 4'h0;
    #5 csN = 1'b0;
    for (int i = 0; i < 8 + adrClk; i++) begin
      w = (i < 8) ? 1 : lanes;
      hostDat = sh[39:36] >> (4 - w);
      hostEn = 4'((5'h01 << w) - 5'h01);
      sh = sh << w;
      pulse();
    end
    hostEn = 4'h0;
    repeat (dumClk) pulse();
    // Sampled 1 ns before the rising edge, 23 ns after the change
    repeat (rdClk) begin
      #23;
      rd = (rd << rdLanes) | 64'(rdLanes == 4 ? ioIn :
           (rdLanes == 2 ? {2'h0, ioIn[1:0]} : {3'h0, ioIn[1]}));
      oe = ioOeN;
      oeAny = oeAny | ~ioOeN;
      #1 sclk = 1'b1;
      #24 sclk = 1'b0;
      noise = ~noise;
    end
    #24 csN = 1'b1;
    #48;
  endtask
endmodule // flash_id_host
`default_nettype wire

/* File: tb.sv */
// Self-checking bench of the identifier and wake instruction block
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] MFR = 8'h3C; // Arbitrary value
  localparam logic [7:0] DEV = 8'h71; // Arbitrary value
  localparam logic [7:0] MEM = 8'h26; // Arbitrary value
  localparam logic [7:0] CAP = 8'h15; // Arbitrary value
  localparam logic [63:0] UID = 64'hA5C3_1E78_0F96_D24B; // Arbitrary
  localparam int WAKE_CYC = 10;
  localparam int IDENT_CYC = 5;

  logic clk, rst, busy, sclk, csN, powerDown, waking;
  logic [3:0] ioIn, ioOut, ioOeN, oe;
  logic [63:0] rd;
  int checks, fail_count, cyc, wakeLen;
  logic [31:0] seed;

  flash_id_cmd #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(MEM),
    .CAPACITY(CAP), .UNIQUE_ID(UID), .WAKE_WAIT_NS(40),
    .WAKE_IDENT_WAIT_NS(20)) flash_id_cmd_inst (.clk(clk), .rst(rst),
    .sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOeN(ioOeN),
    .busy(busy), .powerDown(powerDown), .waking(waking));

  flash_id_host flash_id_host_inst (.sclk(sclk), .csN(csN), .ioIn(ioIn),
    .ioOut(ioOut), .ioOeN(ioOeN));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================
  // Timeout and wake duration
  always @(posedge clk) begin
    cyc++;
    if (waking === 1'b1) wakeLen++;
    if (cyc == 60000) begin
      fail_count++;
      $display("unexpected at %0t: run timed out", $time);
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string msg);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  // First n bits of a repeating pattern, msb first
  function automatic logic [63:0] rep(input logic [63:0] pat, input int plen,
                                      input int n);
    logic [63:0] r;
    r = 64'h0;
    for (int k = 0; k < n; k++) r = (r << 1) | 64'(pat[plen - 1 - k % plen]);
    return r;
  endfunction

  task automatic settle();
    repeat (16) @(posedge clk);
  endtask

  // Identifier read compared with the model stream and lane enables
  task automatic idr(input logic [7:0] op, input logic [31:0] adr,
                     input int ln, input int ac, input int dc, input int rl,
                     input int rc, input logic [63:0] exp,
                     input logic [3:0] oeExp);
    flash_id_host_inst.frame(op, adr, ln, ac, dc, rl, rc, rd, oe);
    chk(rd, exp, "identifier stream");
    chk(64'(oe), 64'(oeExp), "lane enables");
    chk(64'(ioOeN), 64'h000000000000000F, "lines released");
    settle();
  endtask

  task automatic quiet(input logic [7:0] op, input int ac, input int rc);
    flash_id_host_inst.frame(op, (op == 8'h90) ? 32'h0 : $random(seed),
                             1, ac, 0, 1, rc, rd, oe);
    chk(64'(flash_id_host_inst.oeAny), 64'h0, "refused frame drove lines");
    settle();
  endtask

  task automatic wake(input int ac, input int rc, input int len);
    wakeLen = 0;
    flash_id_host_inst.frame(8'hAB, $random(seed), 1, ac, 0, 1, rc, rd, oe);
    // Select stays high for the whole wait before any other frame
    repeat (80) @(posedge clk);
    chk(64'(wakeLen), 64'(len), "wake wait length");
    chk(64'(powerDown), 64'h0, "still powered down");
  endtask

  initial begin
    seed = 32'h82f2ccf5;
    rst <= 1'b1;
    busy = 1'b0;
    checks = 0;
    fail_count = 0;
    cyc = 0;
    wakeLen = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(64'({powerDown, waking, ioOeN}), 64'h0F, "reset state");
    // ==========================================================
    // Identifier reads in every form
    idr(8'h9F, 0, 1, 0, 0, 1, 48, rep({MFR, MEM, CAP}, 24, 48), 4'hD);
    idr(8'h90, 0, 1, 24, 0, 1, 32, rep({MFR, DEV}, 16, 32), 4'hD);
    idr(8'h92, {24'h0, 4'hF, 4'($random(seed))}, 2, 16, 0, 2, 16,
        rep({MFR, DEV}, 16, 32), 4'hC);
    idr(8'h94, {24'h0, 4'hF, 4'($random(seed))}, 4, 8, 4, 4, 8,
        rep({MFR, DEV}, 16, 32), 4'h0);
    repeat (2) idr(8'h4B, $random(seed), 1, 32, 0, 1, 64, UID, 4'hD);
    idr(8'hAB, $random(seed), 1, 24, 0, 1, 24, rep(64'(DEV), 8, 24), 4'hD);
    // ==========================================================
    // Sleep, refusals, and both kinds of wake
    quiet(8'hB9, 0, 0);
    chk(64'(powerDown), 64'h1, "sleep not entered");
    quiet(8'h9F, 0, 24);
    quiet(8'h90, 24, 16);
    chk(64'(powerDown), 64'h1, "woken by other opcode");
    @(posedge clk) busy <= 1'b1;
    settle();
    quiet(8'hAB, 0, 0);
    quiet(8'hAB, 24, 16);
    chk(64'({powerDown, waking}), 64'h2, "busy release acted");
    @(posedge clk) busy <= 1'b0;
    settle();
    wake(0, 0, WAKE_CYC);
    idr(8'h9F, 0, 1, 0, 0, 1, 24, rep({MFR, MEM, CAP}, 24, 24), 4'hD);
    quiet(8'hB9, 0, 0);
    chk(64'(powerDown), 64'h1, "second sleep");
    wake(24, 16, IDENT_CYC);
    chk(rd, rep(64'(DEV), 8, 16), "wake identifier");
    idr(8'h90, 0, 1, 24, 0, 1, 16, 64'({MFR, DEV}), 4'hD);
    test_done();
  end
endmodule // tb
`default_nettype wire
